// *** src/tse_pkg.sv ***
// shared constants and types for the three-wire serial memory link
package tse_pkg;

    // ==================================================================
    // array shape and instruction fields
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int WORDS = 64;
    localparam logic [DATA_W-1:0] WORD_ONES = 16'hffff;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] OP_ERASE = 2'b11;
    localparam logic [1:0] OP_EXT = 2'b00;
    localparam logic [1:0] EXT_PEN = 2'b11;
    localparam logic [1:0] EXT_PDIS = 2'b00;
    localparam logic [1:0] EXT_ERASE_ALL_CMD = 2'b10;
    localparam logic [1:0] EXT_WRITE_ALL_CMD = 2'b01;
    // rising edges per instruction, start bit included
    localparam logic [4:0] CLKS_SHORT = 5'h09;
    localparam logic [4:0] CLKS_LONG = 5'h19;
    localparam logic [4:0] RD_BITS = 5'h10;
    localparam int FRAME_W = 25;

    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int GAP_NS = 100;
    localparam int SCLK_HALF_NS = 500;
    localparam int WRITE_TIME_NS = 2000000;
    localparam int ERASE_TIME_NS = 1000000;
    localparam int ALL_TIME_NS = 15000000;
    localparam logic [1:0] GAP_CYC =
        2'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HALF_CYC =
        4'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int TMR_W = 19;
    localparam logic [TMR_W-1:0] TMR_ONE = 19'h00001;

    // ==================================================================
    // enumerations
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_SHIFT = 2'b01,
        DS_READ = 2'b10,
        DS_DONE = 2'b11
    } tse_dst_t;

    typedef enum logic [1:0] {
        BOP_WRITE = 2'b00,
        BOP_ERASE = 2'b01,
        BOP_ERASE_ALL_CMD = 2'b10,
        BOP_WRITE_ALL_CMD = 2'b11
    } tse_bop_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LO = 3'b001,
        HS_HI = 3'b010,
        HS_RLO = 3'b011,
        HS_RHI = 3'b100,
        HS_GAP = 3'b101,
        HS_POLL = 3'b110
    } tse_hst_t;

    typedef enum logic [2:0] {
        CMD_READ = 3'b000,
        CMD_WRITE = 3'b001,
        CMD_ERASE = 3'b010,
        CMD_PEN = 3'b011,
        CMD_PDIS = 3'b100,
        CMD_ERASE_ALL_CMD = 3'b101,
        CMD_WRITE_ALL_CMD = 3'b110
    } tse_cmd_t;

endpackage

// *** src/tse_link_if.sv ***
// serial link between the memory device and its controlling master
`timescale 1ns/1ps
interface tse_link_if;
    logic chip_select;
    logic sclk;
    logic si_o;
    logic si_oe_n;
    logic so_o;
    logic so_oe_n;
    logic serial_in;
    logic serial_out;

    // released lines float high through the pull-ups
    assign serial_in = si_oe_n ? 1'b1 : si_o;
    assign serial_out = so_oe_n ? 1'b1 : so_o;

    modport dev (
        input chip_select,
        input sclk,
        input serial_in,
        output so_o,
        output so_oe_n
    );

    modport host (
        output chip_select,
        output sclk,
        output si_o,
        output si_oe_n,
        input serial_out
    );
endinterface

// *** src/tse_sync.sv ***
// two-stage synchroniser for pins from outside the clk_sys domain
`timescale 1ns/1ps
module tse_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** src/tse_device.sv ***
// serial memory device end: 64 x 16 array with self-timed programming
`timescale 1ns/1ps

// How it works
// R01: select high, deselect low gives standby
// R02: started programming finishes despite deselect
// R03: master drops select between instructions
// R04: select low resets command logic
// R05: bits sampled and shifted on rising edges
// R06: clock may pause, position is kept
// R07: clock ignored until start bit
// R08: internal timer runs programming cycles
// R09: execute after exact edge count, then idle
// R10: start, two opcode, six address, sixteen data
// R11: opcode and extended opcode decode
// R12: busy times capped per operation
// R13: status after low gap then select
// R14: otherwise output released unless read
// R15: master releases shared wire during status
// R16: dummy zero precedes read data
// R17: start on first rising edge with data
// R18: power up with programming disabled
// R19: read data most significant bit first
// R20: single write erases word first
// R21: status low busy, high ready
// R22: programming ignored while disabled
module tse_device
    import tse_pkg::*;
#(
    parameter logic [tse_pkg::TMR_W-1:0] WRITE_CYC =
        19'(tse_pkg::WRITE_TIME_NS / tse_pkg::CLK_PERIOD_NS),
    parameter logic [tse_pkg::TMR_W-1:0] ERASE_CYC =
        19'(tse_pkg::ERASE_TIME_NS / tse_pkg::CLK_PERIOD_NS),
    parameter logic [tse_pkg::TMR_W-1:0] ALL_CYC =
        19'(tse_pkg::ALL_TIME_NS / tse_pkg::CLK_PERIOD_NS)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    tse_link_if.dev link,
    output logic busy,
    output logic standby
);
    import tse_pkg::*;

    // ==================================================================
    // state
    typedef struct packed {
        tse_dst_t st;
        logic [4:0] cnt;
        logic [23:0] sreg;
        logic [4:0] rcnt;
        logic [DATA_W-1:0] dout;
        logic so;
        logic so_oe_n;
        logic prog_en;
        logic busy;
        tse_bop_t bop;
        logic [TMR_W-1:0] tmr;
        logic [ADDR_W-1:0] baddr;
        logic [DATA_W-1:0] bdata;
        logic fall_seen;
        logic [1:0] gap;
        logic armed;
        logic sclk_d;
        logic standby;
        logic [WORDS-1:0][DATA_W-1:0] mem;
    } tse_dev_t;

    tse_dev_t r;
    tse_dev_t next_r;
    logic [2:0] pins_s;
    logic s_cs;
    logic s_sclk;
    logic s_si;

    // ==================================================================
    // pin synchronisers
    tse_sync #(
        .W(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({link.chip_select, link.sclk, link.serial_in}),
        .q(pins_s)
    );

    assign s_cs = pins_s[2];
    assign s_sclk = pins_s[1];
    assign s_si = pins_s[0];

    // ==================================================================
    // next state
    always_comb begin
        logic rise;
        logic fall;
        logic [23:0] nb;
        logic [1:0] op;
        logic [ADDR_W-1:0] adr;
        logic start;
        tse_bop_t sbop;
        logic [TMR_W-1:0] scyc;
        next_r = r;
        rise = s_sclk && !r.sclk_d;
        fall = !s_sclk && r.sclk_d;
        nb = {r.sreg[22:0], s_si};
        op = 2'h0;
        adr = '0;
        start = 1'b0;
        sbop = BOP_WRITE;
        scyc = WRITE_CYC;
        next_r.sclk_d = s_sclk;

        // R08: internal timer
        if (r.busy) begin
            next_r.tmr = r.tmr - TMR_ONE;
            if (fall) begin
                next_r.fall_seen = 1'b1;
            end
            if (r.tmr == TMR_ONE) begin
                next_r.busy = 1'b0;
                case (r.bop)
                    BOP_WRITE: begin
                        next_r.mem[r.baddr] = r.bdata;
                    end
                    BOP_ERASE: begin
                        next_r.mem[r.baddr] = WORD_ONES;
                    end
                    BOP_ERASE_ALL_CMD: begin
                        for (int i = 0; i < WORDS; i++) begin
                            next_r.mem[i] = WORD_ONES;
                        end
                    end
                    default: begin
                        // no erase here: programming only clears bits
                        for (int i = 0; i < WORDS; i++) begin
                            next_r.mem[i] = r.mem[i] & r.bdata;
                        end
                    end
                endcase
            end
        end

        if (!s_cs) begin
            // R04: deselect resets command logic
            next_r.st = DS_IDLE;
            next_r.cnt = '0;
            next_r.rcnt = '0;
            next_r.so_oe_n = 1'b1;
            next_r.armed = 1'b0;
            // R13: gap counted after the last falling edge
            if (r.busy && r.fall_seen && r.gap != GAP_CYC) begin
                next_r.gap = r.gap + 2'h1;
            end
        end else begin
            next_r.gap = '0;
            // R13: status only after a full low gap
            if (r.gap == GAP_CYC && r.busy) begin
                next_r.armed = 1'b1;
            end
            case (r.st)
                DS_IDLE: begin
                    // R07: wait for start, clocks otherwise ignored
                    // R17: first rising edge with data high
                    if (rise && s_si && !r.busy) begin
                        next_r.st = DS_SHIFT;
                        next_r.cnt = '0;
                        next_r.armed = 1'b0;
                    end
                end
                DS_SHIFT: begin
                    // R05: sample on rising edge
                    // R06: position held between edges
                    if (rise) begin
                        next_r.sreg = nb;
                        next_r.cnt = r.cnt + 5'h01;
                        // R10: opcode then address then data
                        if (r.cnt == CLKS_SHORT - 5'h02) begin
                            op = nb[7:6];
                            adr = nb[5:0];
                            next_r.st = DS_DONE;
                            // R11: opcode decode
                            case (op)
                                OP_READ: begin
                                    // R16: dummy zero first
                                    next_r.so = 1'b0;
                                    next_r.so_oe_n = 1'b0;
                                    next_r.dout = r.mem[adr];
                                    next_r.rcnt = '0;
                                    next_r.st = DS_READ;
                                end
                                OP_ERASE: begin
                                    start = 1'b1;
                                    sbop = BOP_ERASE;
                                    scyc = ERASE_CYC;
                                end
                                OP_WRITE: begin
                                    next_r.st = DS_SHIFT;
                                end
                                default: begin
                                    case (adr[5:4])
                                        EXT_PEN: next_r.prog_en = 1'b1;
                                        EXT_PDIS: next_r.prog_en = 1'b0;
                                        EXT_ERASE_ALL_CMD: begin
                                            start = 1'b1;
                                            sbop = BOP_ERASE_ALL_CMD;
                                            scyc = ALL_CYC;
                                        end
                                        default: next_r.st = DS_SHIFT;
                                    endcase
                                end
                            endcase
                        end else if (r.cnt == CLKS_LONG - 5'h02) begin
                            // R09: executes on the last required edge
                            next_r.st = DS_DONE;
                            start = 1'b1;
                            adr = nb[21:16];
                            sbop = (nb[23:22] == OP_WRITE) ? BOP_WRITE
                                                           : BOP_WRITE_ALL_CMD;
                            scyc = (nb[23:22] == OP_WRITE) ? WRITE_CYC
                                                           : ALL_CYC;
                        end
                    end
                end
                DS_READ: begin
                    if (rise) begin
                        if (r.rcnt == RD_BITS) begin
                            next_r.so_oe_n = 1'b1;
                            next_r.st = DS_DONE;
                        end else begin
                            // R19: most significant bit first
                            next_r.so = r.dout[DATA_W-1];
                            next_r.dout = {r.dout[DATA_W-2:0], 1'b0};
                            next_r.rcnt = r.rcnt + 5'h01;
                        end
                    end
                end
                default: begin
                    // R09: clock and data ignored until deselect
                    next_r.st = DS_DONE;
                end
            endcase
        end

        // R22: nothing starts while programming is disabled
        // R18: enable comes from reset cleared
        if (start && r.prog_en) begin
            next_r.busy = 1'b1;
            next_r.bop = sbop;
            // R12: cycle length per operation
            next_r.tmr = scyc;
            next_r.baddr = adr;
            next_r.bdata = nb[15:0];
            next_r.fall_seen = 1'b0;
            // R20: word erased before the new data lands
            if (sbop == BOP_WRITE) begin
                next_r.mem[adr] = WORD_ONES;
            end
        end

        // R21: low while busy, high when done
        // R14: status only when armed and selected
        if (s_cs && next_r.armed) begin
            next_r.so_oe_n = 1'b0;
            next_r.so = !next_r.busy;
        end

        // R01: standby once deselected and idle
        // R02: busy cycle defers standby
        next_r.standby = !s_cs && !next_r.busy;
    end

    // ==================================================================
    // registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= DS_IDLE;
            r.so_oe_n <= 1'b1;
            r.standby <= 1'b1;
            r.mem <= {WORDS{WORD_ONES}};
        end else begin
            r <= next_r;
        end
    end

    assign link.so_o = r.so;
    assign link.so_oe_n = r.so_oe_n;
    assign busy = r.busy;
    assign standby = r.standby;
endmodule

// *** src/tse_host.sv ***
// controlling master end: frames user commands onto the serial link
`timescale 1ns/1ps
module tse_host
    import tse_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    tse_link_if.host link,
    input wire logic cmd_valid,
    input wire tse_pkg::tse_cmd_t cmd_op,
    input wire logic [tse_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [tse_pkg::DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [tse_pkg::DATA_W-1:0] rsp_data
);
    import tse_pkg::*;

    // ==================================================================
    // state
    typedef struct packed {
        tse_hst_t st;
        logic [3:0] tmr;
        logic [4:0] bitn;
        logic [4:0] nbits;
        logic [FRAME_W-1:0] sreg;
        logic rd;
        logic prog;
        logic [DATA_W-1:0] rdata;
        logic cs;
        logic sclk;
        logic si;
        logic si_oe_n;
        logic ready;
        logic rsp_valid;
        logic [DATA_W-1:0] rsp_data;
    } tse_hst_reg_t;

    tse_hst_reg_t r;
    tse_hst_reg_t next_r;
    logic so_s;

    tse_sync #(
        .W(1)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(link.serial_out),
        .q(so_s)
    );

    // ==================================================================
    // next state
    always_comb begin
        logic tick;
        logic [1:0] op;
        logic [ADDR_W-1:0] adr;
        next_r = r;
        tick = (r.tmr == HALF_CYC - 4'h1);
        next_r.tmr = tick ? 4'h0 : r.tmr + 4'h1;
        next_r.rsp_valid = 1'b0;
        op = OP_EXT;
        adr = cmd_addr;
        case (cmd_op)
            CMD_READ: op = OP_READ;
            CMD_WRITE: op = OP_WRITE;
            CMD_ERASE: op = OP_ERASE;
            CMD_PEN: adr = {EXT_PEN, 4'h0};
            CMD_PDIS: adr = {EXT_PDIS, 4'h0};
            CMD_ERASE_ALL_CMD: adr = {EXT_ERASE_ALL_CMD, 4'h0};
            default: adr = {EXT_WRITE_ALL_CMD, 4'h0};
        endcase

        case (r.st)
            HS_IDLE: begin
                next_r.tmr = '0;
                next_r.ready = 1'b1;
                if (cmd_valid && r.ready) begin
                    next_r.ready = 1'b0;
                    next_r.sreg = {1'b1, op, adr, cmd_data};
                    next_r.nbits = (cmd_op == CMD_WRITE ||
                                    cmd_op == CMD_WRITE_ALL_CMD) ? CLKS_LONG
                                                        : CLKS_SHORT;
                    next_r.rd = (cmd_op == CMD_READ);
                    next_r.prog = (cmd_op == CMD_WRITE ||
                                   cmd_op == CMD_ERASE ||
                                   cmd_op == CMD_ERASE_ALL_CMD ||
                                   cmd_op == CMD_WRITE_ALL_CMD);
                    next_r.bitn = '0;
                    next_r.cs = 1'b1;
                    next_r.si = 1'b1;
                    next_r.si_oe_n = 1'b0;
                    next_r.st = HS_LO;
                end
            end
            HS_LO: begin
                if (tick) begin
                    next_r.sclk = 1'b1;
                    next_r.st = HS_HI;
                end
            end
            HS_HI: begin
                // R16: a read frees the wire one cycle after the last rise,
                // before the device can turn its dummy zero around
                if (r.rd && r.bitn == r.nbits - 5'h01) begin
                    next_r.si_oe_n = 1'b1;
                end
                if (tick) begin
                    next_r.sclk = 1'b0;
                    if (r.bitn == r.nbits - 5'h01) begin
                        // R15: wire left free for the status phase
                        next_r.si_oe_n = 1'b1;
                        next_r.bitn = '0;
                        if (r.rd) begin
                            next_r.st = HS_RLO;
                        end else begin
                            next_r.cs = 1'b0;
                            next_r.st = HS_GAP;
                        end
                    end else begin
                        // R10: frame sent msb first
                        next_r.sreg = {r.sreg[FRAME_W-2:0], 1'b0};
                        next_r.si = r.sreg[FRAME_W-2];
                        next_r.bitn = r.bitn + 5'h01;
                        next_r.st = HS_LO;
                    end
                end
            end
            HS_RLO: begin
                if (tick) begin
                    next_r.sclk = 1'b1;
                    next_r.st = HS_RHI;
                end
            end
            HS_RHI: begin
                if (tick) begin
                    // sampled half a period after the edge that moved it
                    next_r.sclk = 1'b0;
                    next_r.rdata = {r.rdata[DATA_W-2:0], so_s};
                    if (r.bitn == RD_BITS - 5'h01) begin
                        next_r.cs = 1'b0;
                        next_r.st = HS_GAP;
                    end else begin
                        next_r.bitn = r.bitn + 5'h01;
                        next_r.st = HS_RLO;
                    end
                end
            end
            HS_GAP: begin
                // R03: select held low for a half period
                if (tick) begin
                    if (r.prog) begin
                        next_r.cs = 1'b1;
                        next_r.st = HS_POLL;
                    end else begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_data = r.rdata;
                        next_r.st = HS_IDLE;
                    end
                end
            end
            HS_POLL: begin
                // R15: wire stays released while status is read
                if (tick && so_s) begin
                    next_r.cs = 1'b0;
                    next_r.prog = 1'b0;
                    next_r.st = HS_GAP;
                end
            end
            default: begin
                next_r.st = HS_IDLE;
            end
        endcase
    end

    // ==================================================================
    // registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= HS_IDLE;
            r.si_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.chip_select = r.cs;
    assign link.sclk = r.sclk;
    assign link.si_o = r.si;
    assign link.si_oe_n = r.si_oe_n;
    assign cmd_ready = r.ready;
    assign rsp_valid = r.rsp_valid;
    assign rsp_data = r.rsp_data;
endmodule

// *** verification/tse_link_properties.sv ***
// link protocol assertions between host and device
`timescale 1ns/1ps
module tse_link_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chip_select,
    input wire logic sclk,
    input wire logic si_oe_n,
    input wire logic so_o,
    input wire logic so_oe_n,
    input wire logic serial_in
);
    // ==========
    // sclk rises per frame, cycles since sclk last moved
    logic [5:0] rises;
    logic [3:0] held;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rises <= 6'h00;
            held <= 4'h0;
        end else begin
            rises <= chip_select ? rises + 6'($rose(sclk)) : 6'h00;
            held <= $changed(sclk) ? 4'h0 : held + 4'(held != 4'hf);
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_gap_kept: assert property ($fell(chip_select) |=> !chip_select)
        else $error("select gap short");
    // five cycles leave room for the device's input synchroniser
    a_desel_released: assert property (
        (!chip_select)[*5] |-> so_oe_n)
        else $error("output driven while deselected");
    a_no_contention: assert property (!si_oe_n |-> so_oe_n)
        else $error("both ends drive");
    a_sclk_idle: assert property (!chip_select |-> !sclk)
        else $error("sclk moves outside frame");
    a_half_period: assert property ($changed(sclk) |-> held >= 4'h9)
        else $error("sclk half period short");
    a_start_first: assert property (
        chip_select && $rose(sclk) && rises == 6'h00 |-> serial_in)
        else $error("frame without start bit");
    a_frame_len: assert property (
        $fell(chip_select) |-> rises inside {6'h00, 6'h09, 6'h19, 6'h1a})
        else $error("wrong rise count");
    a_dummy_low: assert property (
        $fell(so_oe_n) |-> chip_select && !so_o)
        else $error("first driven bit not low");
endmodule

// *** verification/three_wire_serial_eeprom_interface_tb.sv ***
// self-checking bench: host and device joined on one serial link
`timescale 1ns/1ps
module three_wire_serial_eeprom_interface_tb;
    import tse_pkg::*;
    // ==========
    // shortened programming times
    localparam logic [TMR_W-1:0] WR_T = 19'h00032;
    localparam logic [TMR_W-1:0] ER_T = 19'h0001e;
    localparam logic [TMR_W-1:0] ALL_T = 19'h00050;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    tse_cmd_t cmd_op = CMD_READ;
    logic [ADDR_W-1:0] cmd_addr = 6'h00;
    logic [DATA_W-1:0] cmd_data = 16'h0000;
    logic cmd_ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic busy;
    logic standby;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'hc1fe;
    logic [DATA_W-1:0] mem [WORDS];
    logic en = 1'b0;
    tse_link_if link ();
    always #25 clk_sys = ~clk_sys;
    tse_host i_tse_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.host),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    tse_device #(.WRITE_CYC(WR_T), .ERASE_CYC(ER_T), .ALL_CYC(ALL_T))
        i_tse_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.dev),
        .busy(busy), .standby(standby));
    tse_link_properties i_tse_link_properties (.clk_sys(clk_sys),
        .rst_n(rst_n), .chip_select(link.chip_select), .sclk(link.sclk),
        .si_oe_n(link.si_oe_n), .so_o(link.so_o), .so_oe_n(link.so_oe_n),
        .serial_in(link.serial_in));
    // ==========
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk_w(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_f(string what, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one command through the host, checked against the word model
    task automatic run(tse_cmd_t op, logic [5:0] a, logic [15:0] d);
        int i;
        int blen;
        logic sb;
        logic prog;
        i = 0;
        blen = 0;
        sb = 1'b0;
        prog = en && op inside {CMD_WRITE, CMD_ERASE, CMD_ERASE_ALL_CMD, CMD_WRITE_ALL_CMD};
        while (cmd_ready !== 1'b1 && i < 50) begin
            @(negedge clk_sys);
            i++;
        end
        if (i >= 50) begin
            chk_f("cmd_ready", 1'b1, cmd_ready);
            summarize();
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 4000) begin
            @(negedge clk_sys);
            blen += int'(busy === 1'b1);
            sb |= busy === 1'b1 && standby !== 1'b0;
            i++;
        end
        if (i >= 4000) begin
            chk_f("rsp_valid", 1'b1, rsp_valid);
            summarize();
        end
        chk_f("busy", prog, blen > 0);
        chk_f("busy_len", 1'b1, blen <= int'(op == CMD_WRITE ? WR_T :
            op == CMD_ERASE ? ER_T : ALL_T));
        chk_f("standby_busy", 1'b0, sb);
        chk_f("standby", 1'b1, standby);
        case (op)
            CMD_READ: chk_w("rsp_data", mem[a], rsp_data);
            CMD_PEN: en = 1'b1;
            CMD_PDIS: en = 1'b0;
            CMD_WRITE: if (prog) mem[a] = d;
            CMD_ERASE: if (prog) mem[a] = 16'hffff;
            default: for (int j = 0; j < WORDS; j++) begin
                if (prog) mem[j] = op == CMD_ERASE_ALL_CMD ? 16'hffff : mem[j] & d;
            end
        endcase
    endtask
    // ==========
    // main sequence
    initial begin
        for (int j = 0; j < WORDS; j++) mem[j] = 16'hffff;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int k = 0; k < 7; k++) run(tse_cmd_t'(k), 6'h3f, 16'h1234);
        run(CMD_READ, 6'h3f, 16'h0000);
        run(CMD_PEN, 6'h00, 16'h0000);
        run(CMD_WRITE, 6'h3f, 16'h8001);
        run(CMD_READ, 6'h3f, 16'h0000);
        run(CMD_ERASE_ALL_CMD, 6'h00, 16'h0000);
        run(CMD_WRITE_ALL_CMD, 6'h00, 16'h7ffe);
        run(CMD_READ, 6'h00, 16'h0000);
        // random traffic, each followed by a read of the same word
        repeat (30) begin
            void'(xs());
            run(tse_cmd_t'(seed[2:0] % 3'h7), seed[8:3], seed[31:16]);
            run(CMD_READ, seed[8:3], 16'h0000);
        end
        summarize();
    end
endmodule
